// ---- design/pwm_sync_pkg.sv ----
// Constants shared by the PWM synchronisation and oscillator calibration block.
// Assumes a single 20 MHz system clock and a word-wide plain register port.
//
// What this block does
// RQ1: Five synchronisation methods are chosen by the method-select field of the control register.
// RQ2: Method 1h counts the sync reference period in system clocks into a readable register.
// RQ3: The measured period is 12 bits wide and saturates at 4095 counts.
// RQ4: Method 2h ignores the programmed period and restarts the reference counter on sync rises.
// RQ5: Method 5h counts system clocks between 20 kHz sync rises, with 1000 as the ideal count.
// RQ6: The sync reference is taken as accurate and any deviation trims the oscillator to 20 MHz.
// RQ7: Method 6h calibrates from the sync reference and also restarts the counter on its rises.
// RQ8: Method 7h calibrates from the serial clock, using the rate and cycle-count fields.
// RQ9: Serial-clock calibration times the configured number of cycles and trims to the 20 MHz count.
// RQ10: The configured cycle count sets the window length and thus the calibration accuracy.
// RQ11: The controller supplies one reference waveform on the sync pin to keep the PWM aligned.
// RQ12: Register traffic is taken only while the active-low serial select is held low.
// RQ13: In up counting the reference counter runs from zero to the period value, then back to zero.
// RQ14: While enabled a high-side output is high when its duty value exceeds the counter, else low.
// RQ15: Sync reference and serial clock pass a two-stage synchroniser before edge detection.

package pwm_sync_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int CNT_W = 12;
    localparam int TRIM_W = 8;
    localparam int SC_TIME_W = 16;
    localparam int SC_CYC_W = 7;

    // Register indices on the plain port.
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_A = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_B = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_C = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_PERIOD = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_TRIM = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h7;

    // Control register field positions.
    localparam int F_METHOD_LSB = 0;
    localparam int F_SHAPE_LSB = 4;
    localparam int F_ENABLE = 6;
    localparam int F_RATE_LSB = 8;
    localparam int F_NCYC_LSB = 10;

    // Synchronisation method codes.
    localparam logic [2:0] METHOD_OFF = 3'h0;
    localparam logic [2:0] METHOD_MEASURE = 3'h1;
    localparam logic [2:0] METHOD_SLAVE = 3'h2;
    localparam logic [2:0] METHOD_CAL = 3'h5;
    localparam logic [2:0] METHOD_CAL_SLAVE = 3'h6;
    localparam logic [2:0] METHOD_SCLK_CAL = 3'h7;

    // Counter shape codes.
    localparam logic [1:0] SHAPE_UPDOWN = 2'h0;
    localparam logic [1:0] SHAPE_UP = 2'h1;
    localparam logic [1:0] SHAPE_DOWN = 2'h2;

    // Rates and counts.
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int SYNC_REF_HZ = 20_000;
    localparam logic [CNT_W-1:0] IDEAL_SYNC_COUNT = CNT_W'(SYS_CLK_HZ / SYNC_REF_HZ);
    localparam logic [CNT_W-1:0] SYNC_COUNT_MAX = 12'hfff;
    localparam logic [SC_TIME_W-1:0] SC_TIME_MAX = 16'hffff;

    // Serial clock rate select: system clocks per serial clock cycle for 1, 2, 5, 10 MHz.
    localparam logic [4:0] SC_RATIO_0 = 5'(SYS_CLK_HZ / 1_000_000);
    localparam logic [4:0] SC_RATIO_1 = 5'(SYS_CLK_HZ / 2_000_000);
    localparam logic [4:0] SC_RATIO_2 = 5'(SYS_CLK_HZ / 5_000_000);
    localparam logic [4:0] SC_RATIO_3 = 5'(SYS_CLK_HZ / 10_000_000);

    // Calibration window lengths in serial clock cycles.
    localparam logic [SC_CYC_W-1:0] SC_NCYC_0 = 7'h08;
    localparam logic [SC_CYC_W-1:0] SC_NCYC_1 = 7'h10;
    localparam logic [SC_CYC_W-1:0] SC_NCYC_2 = 7'h20;
    localparam logic [SC_CYC_W-1:0] SC_NCYC_3 = 7'h40;

    // Reset values and trim limits.
    localparam logic [CNT_W-1:0] PERIOD_RESET = 12'h3e8;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;
    localparam logic [TRIM_W-1:0] TRIM_MAX = 8'hff;
    localparam logic [TRIM_W-1:0] TRIM_MIN = 8'h00;

endpackage : pwm_sync_pkg

// ---- design/input_synchroniser.sv ----
// Two-stage synchroniser with rising-edge detection, one lane per input bit.
// Assumes the inputs are asynchronous to clock and reset_n is already synchronous on release.

`timescale 1ns/1ps
`default_nettype none

module input_synchroniser #(
    parameter int WIDTH = 2
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;

    ////////////////////////////////////////////////////////////////////////////
    // Only the second stage is ever looked at; the first may be metastable.
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_lane
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
                last_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_in[i]; // [RQ15]
                sync_q[i] <= meta_q[i]; // [RQ15]
                last_q[i] <= sync_q[i];
            end
        end
        assign rise[i] = sync_q[i] & ~last_q[i]; // [RQ15]
    end

    // The level output is the clean second stage.
    assign level = sync_q;

endmodule : input_synchroniser

`default_nettype wire

// ---- design/pwm_sync_osc_calibration.sv ----
// PWM reference counter with sync-pin slaving and oscillator trim calibration.
// Assumes a 20 MHz clock, a plain register port driven synchronously, and an
// analog oscillator that follows osc_trim (higher code means faster clock).
//
// The register addresses and the plain strobed port were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module pwm_sync_osc_calibration
    import pwm_sync_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sync_ref,
    input wire logic serial_clock,
    input wire logic serial_select_n,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata,
    output logic [2:0] phase_high,
    output logic [TRIM_W-1:0] osc_trim
);

    typedef struct packed {
        logic [2:0] sync_method_select;
        logic [1:0] counter_shape_select;
        logic enable;
        logic [1:0] serial_clock_rate_select;
        logic [1:0] calibration_cycle_count;
        logic [CNT_W-1:0] pwm_period_setting;
        logic [2:0][CNT_W-1:0] phase_duty_value;
        logic [CNT_W-1:0] ref_cnt;
        logic down;
        logic [CNT_W-1:0] meas;
        logic armed;
        logic [CNT_W-1:0] sync_period_count;
        logic [TRIM_W-1:0] trim;
        logic sc_run;
        logic [SC_TIME_W-1:0] sc_time;
        logic [SC_CYC_W-1:0] sc_cyc;
        logic [DATA_W-1:0] rdata;
        logic [2:0] hs;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] in_level;
    logic [1:0] in_rise;
    logic sync_rise;
    logic sclk_rise;
    logic [CNT_W-1:0] meas_inc;
    logic [CNT_W-1:0] period_value;
    logic slave_mode;
    logic cal_mode;
    logic [SC_CYC_W-1:0] sc_target;
    logic [4:0] sc_ratio;
    logic [SC_TIME_W-1:0] sc_expected;
    logic [SC_TIME_W-1:0] sc_time_inc;
    logic sc_done;
    logic bus_take_wr;
    logic bus_take_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops so every state flop leaves reset together.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Lane 0 is the sync reference, lane 1 the serial clock.
    input_synchroniser #(
        .WIDTH(2)
    ) u_sync (
        .clock(clock),
        .reset_n(rst_n),
        .async_in({serial_clock, sync_ref}),
        .level(in_level),
        .rise(in_rise)
    );
    assign sync_rise = in_rise[0];
    assign sclk_rise = in_rise[1];

    ////////////////////////////////////////////////////////////////////////////
    // Method decode and derived values.
    assign slave_mode = (st_q.sync_method_select == METHOD_SLAVE) ||
                        (st_q.sync_method_select == METHOD_CAL_SLAVE); // [RQ1] [RQ4] [RQ7]
    assign cal_mode = (st_q.sync_method_select == METHOD_CAL) ||
                      (st_q.sync_method_select == METHOD_CAL_SLAVE); // [RQ1] [RQ5] [RQ7]
    // Saturating count of cycles since the last sync rise.
    assign meas_inc = (st_q.meas == SYNC_COUNT_MAX) ? SYNC_COUNT_MAX :
                      CNT_W'(st_q.meas + 12'h001); // [RQ3]
    // When slaved, the last measured sync period stands in for the programmed one.
    assign period_value = slave_mode ? st_q.sync_period_count : st_q.pwm_period_setting; // [RQ4]
    // Serial calibration window; a longer window gives finer resolution per trim step.
    always_comb begin
        unique case (st_q.calibration_cycle_count)
            2'h0: sc_target = SC_NCYC_0; // [RQ10]
            2'h1: sc_target = SC_NCYC_1;
            2'h2: sc_target = SC_NCYC_2;
            2'h3: sc_target = SC_NCYC_3;
        endcase
        unique case (st_q.serial_clock_rate_select)
            2'h0: sc_ratio = SC_RATIO_0; // [RQ8]
            2'h1: sc_ratio = SC_RATIO_1;
            2'h2: sc_ratio = SC_RATIO_2;
            2'h3: sc_ratio = SC_RATIO_3;
        endcase
    end
    assign sc_expected = SC_TIME_W'(sc_target) * SC_TIME_W'(sc_ratio); // [RQ9]
    assign sc_time_inc = (st_q.sc_time == SC_TIME_MAX) ? SC_TIME_MAX :
                         SC_TIME_W'(st_q.sc_time + 16'h0001);
    assign sc_done = (st_q.sync_method_select == METHOD_SCLK_CAL) && st_q.sc_run && sclk_rise &&
                     (SC_CYC_W'(st_q.sc_cyc + 7'h01) == sc_target); // [RQ9]
    // Register traffic counts only while the serial select is low.
    assign bus_take_wr = bus_wr && !serial_select_n; // [RQ12]
    assign bus_take_rd = bus_rd && !serial_select_n; // [RQ12]

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole block.
    always_comb begin
        st_d = st_q;
        st_d.rdata = '0;

        // Register writes.
        if (bus_take_wr) begin
            unique case (bus_addr)
                ADDR_CONTROL: begin
                    st_d.sync_method_select = bus_wdata[F_METHOD_LSB +: 3]; // [RQ1]
                    st_d.counter_shape_select = bus_wdata[F_SHAPE_LSB +: 2];
                    st_d.enable = bus_wdata[F_ENABLE];
                    st_d.serial_clock_rate_select = bus_wdata[F_RATE_LSB +: 2]; // [RQ8]
                    st_d.calibration_cycle_count = bus_wdata[F_NCYC_LSB +: 2]; // [RQ8]
                end
                ADDR_PERIOD: st_d.pwm_period_setting = bus_wdata[CNT_W-1:0];
                ADDR_DUTY_A: st_d.phase_duty_value[0] = bus_wdata[CNT_W-1:0];
                ADDR_DUTY_B: st_d.phase_duty_value[1] = bus_wdata[CNT_W-1:0];
                ADDR_DUTY_C: st_d.phase_duty_value[2] = bus_wdata[CNT_W-1:0];
                default: ;
            endcase
        end

        // Register reads; data stand only in the following cycle, idle cycles give zero.
        if (bus_take_rd) begin
            unique case (bus_addr)
                ADDR_CONTROL: st_d.rdata = {4'h0, st_q.calibration_cycle_count,
                                            st_q.serial_clock_rate_select, 1'b0, st_q.enable,
                                            st_q.counter_shape_select, 1'b0,
                                            st_q.sync_method_select};
                ADDR_PERIOD: st_d.rdata = DATA_W'(st_q.pwm_period_setting);
                ADDR_DUTY_A: st_d.rdata = DATA_W'(st_q.phase_duty_value[0]);
                ADDR_DUTY_B: st_d.rdata = DATA_W'(st_q.phase_duty_value[1]);
                ADDR_DUTY_C: st_d.rdata = DATA_W'(st_q.phase_duty_value[2]);
                ADDR_SYNC_PERIOD: st_d.rdata = DATA_W'(st_q.sync_period_count); // [RQ2]
                ADDR_TRIM: st_d.rdata = DATA_W'(st_q.trim);
                ADDR_STATUS: st_d.rdata = {13'h0000, st_q.sc_run, st_q.armed, in_level[0]};
            endcase
        end

        // Sync period measurement runs in every method so slaving has a period.
        if (sync_rise) begin
            st_d.meas = '0;
            st_d.armed = 1'b1;
            if (st_q.armed) begin
                st_d.sync_period_count = meas_inc; // [RQ2] [RQ3]
            end
            // Reference taken as exact: a high count means our clock runs fast.
            if (cal_mode && st_q.armed) begin
                if (meas_inc > IDEAL_SYNC_COUNT && st_q.trim != TRIM_MIN) begin
                    st_d.trim = TRIM_W'(st_q.trim - 8'h01); // [RQ5] [RQ6]
                end else if (meas_inc < IDEAL_SYNC_COUNT && st_q.trim != TRIM_MAX) begin
                    st_d.trim = TRIM_W'(st_q.trim + 8'h01); // [RQ5] [RQ6]
                end
            end
        end else begin
            st_d.meas = meas_inc; // [RQ3]
        end

        // Serial clock calibration windows run back to back while method 7h is selected.
        if (st_q.sync_method_select != METHOD_SCLK_CAL) begin
            st_d.sc_run = 1'b0;
        end else if (!st_q.sc_run) begin
            if (sclk_rise) begin
                st_d.sc_run = 1'b1; // [RQ8]
                st_d.sc_time = '0;
                st_d.sc_cyc = '0;
            end
        end else if (sc_done) begin
            st_d.sc_time = '0;
            st_d.sc_cyc = '0;
            if (sc_time_inc > sc_expected && st_q.trim != TRIM_MIN) begin
                st_d.trim = TRIM_W'(st_q.trim - 8'h01); // [RQ9]
            end else if (sc_time_inc < sc_expected && st_q.trim != TRIM_MAX) begin
                st_d.trim = TRIM_W'(st_q.trim + 8'h01); // [RQ9]
            end
        end else begin
            st_d.sc_time = sc_time_inc;
            if (sclk_rise) begin
                st_d.sc_cyc = SC_CYC_W'(st_q.sc_cyc + 7'h01);
            end
        end

        // Reference counter; held at its start point while disabled.
        if (!st_q.enable) begin
            st_d.ref_cnt = (st_q.counter_shape_select == SHAPE_UP) ? '0 : period_value;
            st_d.down = 1'b1;
        end else if (slave_mode && sync_rise) begin
            st_d.ref_cnt = (st_q.counter_shape_select == SHAPE_UP) ? '0 : period_value; // [RQ4] [RQ7]
            st_d.down = 1'b1;
        end else begin
            unique case (st_q.counter_shape_select)
                SHAPE_UP: begin
                    st_d.ref_cnt = (st_q.ref_cnt >= period_value) ? '0 :
                                   CNT_W'(st_q.ref_cnt + 12'h001); // [RQ13]
                end
                SHAPE_DOWN: begin
                    st_d.ref_cnt = (st_q.ref_cnt == '0) ? period_value :
                                   CNT_W'(st_q.ref_cnt - 12'h001);
                end
                default: begin
                    // V shape: down to zero, up to the period, then down again.
                    if (st_q.down) begin
                        st_d.ref_cnt = (st_q.ref_cnt == '0) ? 12'h001 : CNT_W'(st_q.ref_cnt - 12'h001);
                        st_d.down = (st_q.ref_cnt != '0);
                    end else begin
                        st_d.ref_cnt = (st_q.ref_cnt >= period_value) ? CNT_W'(st_q.ref_cnt - 12'h001) :
                                       CNT_W'(st_q.ref_cnt + 12'h001);
                        st_d.down = (st_q.ref_cnt >= period_value);
                    end
                end
            endcase
        end

        // High-side compare, registered for clean outputs.
        for (int p = 0; p < 3; p++) begin
            st_d.hs[p] = st_q.enable && (st_q.phase_duty_value[p] > st_q.ref_cnt); // [RQ14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.pwm_period_setting <= PERIOD_RESET;
            st_q.ref_cnt <= PERIOD_RESET;
            st_q.down <= 1'b1;
            st_q.trim <= TRIM_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata = st_q.rdata;
    assign phase_high = st_q.hs;
    assign osc_trim = st_q.trim;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the block's own behaviour.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_hs_disabled_low: assert property (!st_q.enable |=> phase_high == 3'h0) // [RQ14]
        else $error("High-side output active while disabled.");
    a_hs_duty_compare: assert property (st_q.enable |=>
        phase_high[0] == ($past(st_q.phase_duty_value[0]) > $past(st_q.ref_cnt))) // [RQ14]
        else $error("Phase A output does not follow duty compare.");
    a_period_capture: assert property (sync_rise && st_q.armed |=>
        st_q.sync_period_count == (($past(st_q.meas) == SYNC_COUNT_MAX) ? SYNC_COUNT_MAX :
                                   CNT_W'($past(st_q.meas) + 12'h001))) // [RQ2]
        else $error("Sync period not captured from cycle count.");
    a_meas_saturate: assert property (st_q.meas == SYNC_COUNT_MAX && !sync_rise |=>
        st_q.meas == SYNC_COUNT_MAX) // [RQ3]
        else $error("Period counter wrapped instead of saturating.");
    a_slave_restart: assert property (st_q.enable && slave_mode && sync_rise &&
        st_q.counter_shape_select == SHAPE_UP |=> st_q.ref_cnt == 12'h000) // [RQ4]
        else $error("Counter not restarted on sync rise.");
    a_up_wrap: assert property (st_q.enable && !(slave_mode && sync_rise) &&
        st_q.counter_shape_select == SHAPE_UP && st_q.ref_cnt >= period_value |=>
        st_q.ref_cnt == 12'h000) // [RQ13]
        else $error("Up counter did not return to zero at period.");
    a_trim_fast: assert property (cal_mode && sync_rise && st_q.armed &&
        meas_inc > IDEAL_SYNC_COUNT && st_q.trim != TRIM_MIN |=>
        st_q.trim == TRIM_W'($past(st_q.trim) - 8'h01)) // [RQ6]
        else $error("Fast oscillator not trimmed down.");
    a_trim_slow: assert property (cal_mode && sync_rise && st_q.armed &&
        meas_inc < IDEAL_SYNC_COUNT && st_q.trim != TRIM_MAX |=>
        st_q.trim == TRIM_W'($past(st_q.trim) + 8'h01)) // [RQ5]
        else $error("Slow oscillator not trimmed up.");
    a_sclk_trim: assert property (sc_done && sc_time_inc > sc_expected &&
        st_q.trim != TRIM_MIN |=> st_q.trim == TRIM_W'($past(st_q.trim) - 8'h01)) // [RQ9]
        else $error("Serial window did not trim down.");
    a_select_gate: assert property (serial_select_n && bus_wr |=> $stable(st_q.pwm_period_setting)
        && $stable(st_q.sync_method_select)) // [RQ12]
        else $error("Write taken while serial select high.");
    a_read_gate: assert property (serial_select_n |=> bus_rdata == 16'h0000) // [RQ12]
        else $error("Read answered while serial select high.");

    c_cal_step: cover property (cal_mode && sync_rise && st_q.armed);
    c_slave_restart: cover property (slave_mode && sync_rise && st_q.enable);
    c_sclk_window: cover property (sc_done);
    c_meas_saturated: cover property (st_q.meas == SYNC_COUNT_MAX);

endmodule : pwm_sync_osc_calibration

`default_nettype wire

// ---- tb/mcu_sync_partner.sv ----
// Controller-side timer model driving the sync reference and serial clock pins.
// Assumes the bench sets the periods in system clocks; zero holds a pin low.
`timescale 1ns/1ps
`default_nettype none
module mcu_sync_partner (
    input wire logic clock,
    input wire logic [12:0] sync_period,
    input wire logic [3:0] sclk_period,
    output logic sync_ref,
    output logic serial_clock
);
    logic [12:0] sc_q = 13'h0;
    logic [3:0] kc_q = 4'h0;
    logic sr_q = 1'b0;
    logic sk_q = 1'b0;
    // Sync reference high in the first half of each period, serial clock high for its first cycle only.
    // A new period applies from the current phase, so the change needs no restart.
    always @(posedge clock) begin
        sc_q <= (sc_q + 13'h1 >= sync_period) ? 13'h0 : sc_q + 13'h1;
        sr_q <= (sync_period != 13'h0) && (sc_q < (sync_period >> 1));
        kc_q <= (kc_q + 4'h1 >= sclk_period) ? 4'h0 : kc_q + 4'h1;
        sk_q <= (sclk_period != 4'h0) && (kc_q < 4'h1);
    end
    assign sync_ref = sr_q;
    assign serial_clock = sk_q;
endmodule : mcu_sync_partner
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the PWM sync and oscillator calibration block.
// Assumes the timer model above on the sync pins and a plain register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pwm_sync_pkg::*;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] w;
        logic [DATA_W-1:0] e;
    } row_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic serial_select_n = 1'b0;
    logic [ADDR_W-1:0] bus_addr = 3'h0;
    logic [DATA_W-1:0] bus_wdata = 16'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [12:0] sync_period = 13'h0;
    logic [3:0] sclk_period = 4'h0;
    wire logic sync_ref;
    wire logic serial_clock;
    wire logic [DATA_W-1:0] bus_rdata;
    wire logic [2:0] phase_high;
    wire logic [TRIM_W-1:0] osc_trim;
    int num_errors = 0;
    int n_checks = 0;
    int hi;
    logic [DATA_W-1:0] rv;
    logic [TRIM_W-1:0] t0;
    // Read-only places must ignore writes; high bits above 12 read zero.
    row_t rows [6] = '{'{ADDR_DUTY_A, 16'h0abc, 16'h0abc}, '{ADDR_DUTY_B, 16'h0fff, 16'h0fff},
        '{ADDR_DUTY_C, 16'h0001, 16'h0001}, '{ADDR_SYNC_PERIOD, 16'h0555, 16'h0000},
        '{ADDR_TRIM, 16'h0011, 16'h0080}, '{ADDR_PERIOD, 16'hffff, 16'h0fff}};
    ////////////////////////////////////////////////////////////////////////////////
    mcu_sync_partner u_mcu (.clock(clock), .sync_period(sync_period), .sclk_period(sclk_period),
        .sync_ref(sync_ref), .serial_clock(serial_clock));
    pwm_sync_osc_calibration u_dut (.clock(clock), .reset_n(reset_n), .sync_ref(sync_ref),
        .serial_clock(serial_clock), .serial_select_n(serial_select_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .phase_high(phase_high), .osc_trim(osc_trim));
    // 20 MHz system clock.
    initial begin
        forever #25 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd_reg
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cycles
    task automatic count_high(input int p, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clock);
            #1 c += int'(phase_high[p] === 1'b1);
        end
    endtask : count_high
    function automatic logic [DATA_W-1:0] ctl(input logic [2:0] m, input logic [1:0] s,
        input logic e, input logic [1:0] r, input logic [1:0] n);
        ctl = (DATA_W'(m) << F_METHOD_LSB) | (DATA_W'(s) << F_SHAPE_LSB) |
            (DATA_W'(e) << F_ENABLE) | (DATA_W'(r) << F_RATE_LSB) | (DATA_W'(n) << F_NCYC_LSB);
    endfunction : ctl
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, table, then the sync and calibration cases.
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_reg(ADDR_PERIOD, rv);
        check(rv, 16'h03e8);
        rd_reg(ADDR_TRIM, rv);
        check(rv, 16'h0080);
        check(DATA_W'(phase_high), 16'h0000);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, rv);
            check(rv, rows[i].e);
        end
        serial_select_n <= 1'b1;
        wr_reg(ADDR_PERIOD, 16'h0222);
        rd_reg(ADDR_PERIOD, rv);
        check(rv, 16'h0000);
        serial_select_n <= 1'b0;
        rd_reg(ADDR_PERIOD, rv);
        check(rv, 16'h0fff);
        wr_reg(ADDR_CONTROL, ctl(METHOD_MEASURE, SHAPE_UP, 1'b0, 2'h0, 2'h0));
        sync_period <= 13'd1000;
        cycles(3500);
        rd_reg(ADDR_SYNC_PERIOD, rv);
        check(rv, 16'd1000);
        wr_reg(ADDR_CONTROL, ctl(METHOD_CAL, SHAPE_UP, 1'b0, 2'h0, 2'h0));
        cycles(2100);
        check(DATA_W'(osc_trim), 16'h0080);
        sync_period <= 13'd1001;
        cycles(3100);
        check(DATA_W'(osc_trim < 8'h80), 16'h0001);
        t0 = osc_trim;
        sync_period <= 13'd999;
        cycles(4000);
        check(DATA_W'(osc_trim > t0), 16'h0001);
        wr_reg(ADDR_CONTROL, ctl(METHOD_MEASURE, SHAPE_UP, 1'b0, 2'h0, 2'h0));
        sync_period <= 13'd5000;
        cycles(11000);
        rd_reg(ADDR_SYNC_PERIOD, rv);
        check(rv, 16'h0fff);
        sync_period <= 13'd1000;
        wr_reg(ADDR_DUTY_A, 16'd100);
        wr_reg(ADDR_PERIOD, 16'd300);
        // Up and down shapes both repeat every period plus one cycles, so all phases count alike.
        for (int s = 1; s < 3; s++) begin
            wr_reg(ADDR_CONTROL, ctl(METHOD_OFF, 2'(s), 1'b1, 2'h0, 2'h0));
            cycles(10);
            count_high(0, 903, hi);
            check(DATA_W'(hi), 16'd300);
            count_high(1, 903, hi);
            check(DATA_W'(hi), 16'd903);
            count_high(2, 903, hi);
            check(DATA_W'(hi), 16'd3);
        end
        // Both slave methods must follow the sync rises, not the 301-cycle period.
        for (int k = 0; k < 2; k++) begin
            wr_reg(ADDR_CONTROL, ctl(k == 0 ? METHOD_SLAVE : METHOD_CAL_SLAVE, SHAPE_UP,
                1'b1, 2'h0, 2'h0));
            cycles(2100);
            count_high(0, 2000, hi);
            check(DATA_W'(hi), 16'd200);
        end
        wr_reg(ADDR_CONTROL, ctl(METHOD_OFF, SHAPE_UP, 1'b0, 2'h0, 2'h0));
        count_high(0, 500, hi);
        check(DATA_W'(hi), 16'd0);
        sync_period <= 13'd0;
        sclk_period <= 4'd2;
        wr_reg(ADDR_CONTROL, ctl(METHOD_SCLK_CAL, SHAPE_UP, 1'b0, 2'h3, 2'h0));
        t0 = osc_trim;
        cycles(200);
        check(DATA_W'(osc_trim), DATA_W'(t0));
        sclk_period <= 4'd3;
        cycles(200);
        check(DATA_W'(osc_trim < t0), 16'h0001);
        wr_reg(ADDR_CONTROL, ctl(METHOD_SCLK_CAL, SHAPE_UP, 1'b0, 2'h0, 2'h1));
        t0 = osc_trim;
        cycles(400);
        check(DATA_W'(osc_trim > t0), 16'h0001);
        tally_and_finish();
    end
    // Watchdog well beyond the roughly 38700 cycles the sequence needs.
    initial begin
        repeat (80000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
